/* File: sfh_flash_model.sv */
module sfh_flash_model (
    input  wire logic        sck,
    input  wire logic        cs_n,
    input  wire logic        reset_n,
    input  wire logic [3:0]  dq_o,
    input  wire logic [3:0]  dq_oe,
    input  wire logic [2:0]  out_w,
    input  wire logic [7:0]  out_byte,
    input  wire logic        ddr,
    output logic      [3:0]  dq_i,
    output logic [3:0][15:0] lane_log
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // state of the memory side
    // ------------------------------------------------------------
    logic [7:0] sh_q;           // output byte, msb leaves first
    logic [3:0] flt_q = 4'h0;   // last wire level, inverted while nobody drives
    logic       act;            // selected and out of reset
    logic [3:0] men;            // lanes driven by the memory
    logic [3:0] mval;           // levels on those lanes

    assign act = !cs_n && reset_n;

    // capture on rise, both edges in double rate; frozen clock moves nothing
    always @(sck) begin
        if (act && (sck || ddr)) begin
            for (int l = 0; l < 4; l++) lane_log[l] <= {lane_log[l][14:0], dq_o[l]};
        end
        // reload outside output phases so the first bits wait on the lines
        if (!act || out_w == 3'h0) begin
            sh_q <= out_byte;
        end else if (!sck) begin
            sh_q <= sh_q << out_w;
        end
        flt_q <= dq_i;
    end

    // drive only in output phases; dummy and input phases leave lanes free
    always_comb begin
        men  = 4'h0;
        mval = 4'h0;
        if (act) begin
            case (out_w)
                3'h1: begin men = 4'h2; mval = {2'h0, sh_q[7], 1'b0}; end
                3'h2: begin men = 4'h3; mval = {2'h0, sh_q[7:6]}; end
                3'h4: begin men = 4'hf; mval = sh_q[7:4]; end
                default: ;
            endcase
        end
    end

    // wire level: host driver first, then memory, else a changing pattern
    always_comb begin
        for (int l = 0; l < 4; l++) dq_i[l] = dq_oe[l] ? dq_o[l] : men[l] ? mval[l] : ~flt_q[l];
    end
endmodule

/* File: sfh_host.sv */
// Notes on behaviour
// - reset pin held low minimum pulse
// - select high means standby, lanes released
// - instruction msb first, one bit per rise
// - pause high freezes command; low resumes
// - reset high, select low, clock toggling
// - single input drives lane zero only
// - single dummy: host drives no lane
// - dual input drives lanes zero and one
// - dual dummy: lanes carry no meaning
// - quad page program address on lane zero
// - quad input drives all four lanes
// - double-rate single input on lane zero
// - double-rate dual input on two lanes
// - double-rate quad input on four lanes
module sfh_host import sfh_pkg::*; #(
    parameter int POWERUP_CYC = POWERUP_WAIT_CYC
) (
    input  wire logic       clk_sys,
    input  wire logic       reset,
    input  wire logic       clk_link,
    input  wire logic       hw_reset_req,
    input  wire logic       pause_req,
    input  wire logic       req_valid,
    input  wire sfh_req_s   req,
    output logic            req_ready,
    output logic [7:0]      rsp_data,
    output logic            rsp_valid,
    output logic            link_ready,
    output logic            link_sample_q,
    input  wire logic [3:0] dq_i,
    output sfh_pins_s       pins
);
    // ------------------------------------------------------------
    // host state
    // ------------------------------------------------------------
    typedef enum {ST_POWERUP, ST_RST_LOW, ST_RST_REC, ST_STANDBY, ST_SHIFT, ST_PAUSE} sfh_st_e;
    sfh_st_e         st_q;         // interface state
    logic [CNT_W-1:0] wait_q;       // wait counter
    logic [1:0]      half_q;       // sck half period counter
    logic [3:0]      bits_q;       // bits left in the byte
    logic [7:0]      sh_q;         // shift register
    sfh_req_s        cur_q;        // phase being run
    logic [3:0]      dq_s;         // synchronised lanes
    logic            pause_s;      // synchronised pause request
    logic            rise;         // sck about to rise
    logic            take;         // request accepted at this edge
    logic            hold_now;     // pause seen while sck is low
    logic [3:0]      bpb;          // bits per edge

    // dq comes from the pins, pause may come from anywhere
    sfh_sync2 #(.W(5)) u_sync (
        .clk   (clk_sys),
        .reset (reset),
        .din   ({pause_req, dq_i}),
        .dout  ({pause_s, dq_s})
    );

    assign bpb  = sfh_bits_per_beat(cur_q.width, cur_q.instr);
    assign rise = (st_q == ST_SHIFT) && (half_q == 2'(SCK_HALF_CYC - 1)) && !pins.sck;
    // a request counts only when ready was high, never while a reset is being started
    assign take = req_valid && req_ready && !(st_q == ST_STANDBY && hw_reset_req);
    // freezing only with sck low keeps the frozen level that of a clock held low
    assign hold_now = pause_s && !pins.sck;

    // ------------------------------------------------------------
    // state sequencing
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            st_q   <= ST_POWERUP;
            wait_q <= '0;
        end else begin
            case (st_q)
                ST_POWERUP: begin
                    wait_q <= wait_q + 1'b1;
                    if (wait_q == CNT_W'(POWERUP_CYC - 1)) begin
                        st_q   <= ST_STANDBY;
                        wait_q <= '0;
                    end
                end
                ST_RST_LOW: begin
                    wait_q <= wait_q + 1'b1;
                    if (wait_q == CNT_W'(HWRESET_PULSE_CYC - 1)) begin
                        st_q   <= ST_RST_REC;
                        wait_q <= '0;
                    end
                end
                ST_RST_REC: begin
                    wait_q <= wait_q + 1'b1;
                    if (wait_q == CNT_W'(HWRESET_RECOVER_CYC - 1)) begin
                        st_q   <= ST_STANDBY;
                        wait_q <= '0;
                    end
                end
                ST_STANDBY: begin
                    if (hw_reset_req) st_q <= ST_RST_LOW;
                    else if (take && req.phase != SFH_PH_END) st_q <= ST_SHIFT;
                end
                ST_SHIFT: begin
                    // an accepted close wins: select rises, so there is nothing to freeze
                    if (take && req.phase == SFH_PH_END) st_q <= ST_STANDBY;
                    // pause only taken with sck low so the command freezes cleanly
                    else if (hold_now) st_q <= ST_PAUSE;
                end
                ST_PAUSE: begin
                    if (!pause_s) st_q <= ST_SHIFT;
                end
                default: st_q <= ST_POWERUP;
            endcase
        end
    end

    // ------------------------------------------------------------
    // sck, shifting and capture
    // ------------------------------------------------------------
    // a limitation: sck holds low between phases until the next request
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            half_q    <= '0;
            bits_q    <= '0;
            sh_q      <= BYTE_ZERO;
            cur_q     <= '0;
            rsp_data  <= BYTE_ZERO;
            rsp_valid <= 1'b0;
            pins.sck  <= 1'b0;
        end else begin
            rsp_valid <= 1'b0;
            if ((st_q == ST_STANDBY || st_q == ST_SHIFT) && take
                && req.phase != SFH_PH_END) begin
                cur_q  <= req;
                sh_q   <= req.data;
                bits_q <= 4'h8;
                half_q <= '0;
            end else if (st_q == ST_SHIFT && !hold_now && (bits_q != 4'h0 || pins.sck)) begin
                // a single-rate byte ends on a rise, so one more half period brings sck low
                half_q <= (half_q == 2'(SCK_HALF_CYC - 1)) ? 2'h0 : half_q + 1'b1;
                if (half_q == 2'(SCK_HALF_CYC - 1)) begin
                    pins.sck <= ~pins.sck;
                    if ((rise || cur_q.ddr) && bits_q != 4'h0) begin
                        bits_q <= bits_q - bpb;
                        if (cur_q.phase == SFH_PH_OUT) begin
                            case (cur_q.width)
                                SFH_W_DUAL: sh_q <= {sh_q[5:0], dq_s[1:0]};
                                SFH_W_QUAD: sh_q <= {sh_q[3:0], dq_s};
                                default:    sh_q <= {sh_q[6:0], dq_s[1]};
                            endcase
                        end else begin
                            sh_q <= sh_q << bpb;
                        end
                        if (bits_q == bpb && cur_q.phase == SFH_PH_OUT) begin
                            rsp_valid <= 1'b1;
                            rsp_data  <= (cur_q.width == SFH_W_QUAD) ? {sh_q[3:0], dq_s} :
                                         (cur_q.width == SFH_W_DUAL) ? {sh_q[5:0], dq_s[1:0]} :
                                                                       {sh_q[6:0], dq_s[1]};
                        end
                    end
                end
            end else if (st_q != ST_SHIFT && st_q != ST_PAUSE) begin
                pins.sck <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // pin drive
    // ------------------------------------------------------------
    // enables are a function of the phase, so select rising drops every lane
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pins.cs_n    <= 1'b1;
            pins.reset_n <= 1'b1;
            pins.dq_o    <= 4'h0;
            pins.dq_oe   <= LANE_OE_OFF;
            req_ready    <= 1'b0;
            link_ready   <= 1'b0;
        end else begin
            pins.reset_n <= (st_q != ST_RST_LOW);
            pins.cs_n    <= !(st_q == ST_SHIFT || st_q == ST_PAUSE);
            link_ready   <= (st_q == ST_STANDBY);
            // ready drops for at least one cycle after each handshake so a request is taken once
            req_ready    <= !(req_valid && req_ready) &&
                            ((st_q == ST_STANDBY && !hw_reset_req) ||
                             (st_q == ST_SHIFT && bits_q == 4'h0 && !pins.sck && !hold_now));
            if (st_q == ST_SHIFT && cur_q.phase == SFH_PH_IN) begin
                pins.dq_oe <= sfh_lane_mask(cur_q.width, cur_q.instr);
                case (bpb)
                    4'h4:    pins.dq_o <= sh_q[7:4];
                    4'h2:    pins.dq_o <= {2'b00, sh_q[7:6]};
                    default: pins.dq_o <= {3'b000, sh_q[7]};
                endcase
            end else if (st_q == ST_PAUSE && cur_q.phase == SFH_PH_IN) begin
                pins.dq_oe <= sfh_lane_mask(cur_q.width, cur_q.instr);
            end else begin
                // dummy and output phases release all lanes ahead of turnaround
                pins.dq_oe <= LANE_OE_OFF;
                pins.dq_o  <= 4'h0;
            end
        end
    end

    // ------------------------------------------------------------
    // link clock observer
    // ------------------------------------------------------------
    logic sel_meta_q;   // first stage on clk_link
    // the link clock samples select so link logic sees frame state
    always_ff @(posedge clk_link) begin
        sel_meta_q    <= !pins.cs_n;
        link_sample_q <= sel_meta_q;
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_rst_low;
        !pins.reset_n [*2];
    endsequence

    AST_POWERUP_QUIET: assert property (@(posedge clk_sys) disable iff (reset)
        st_q == ST_POWERUP |=> pins.cs_n && pins.dq_oe == 4'h0)
        else $error("activity during power-up");
    AST_STANDBY_RELEASE: assert property (@(posedge clk_sys) disable iff (reset)
        pins.cs_n |-> pins.dq_oe == 4'h0)
        else $error("lane driven with select high");
    AST_RESET_PULSE: assert property (@(posedge clk_sys) disable iff (reset)
        $fell(pins.reset_n) |-> s_rst_low)
        else $error("reset pulse too short");
    AST_RESET_SELECT: assert property (@(posedge clk_sys) disable iff (reset)
        !pins.cs_n |-> pins.reset_n)
        else $error("reset low during frame");
    AST_OUT_RELEASED: assert property (@(posedge clk_sys) disable iff (reset)
        st_q == ST_SHIFT && cur_q.phase != SFH_PH_IN |=> pins.dq_oe == 4'h0)
        else $error("host drives during output or dummy");
    AST_SINGLE_LANE: assert property (@(posedge clk_sys) disable iff (reset)
        st_q == ST_SHIFT && cur_q.phase == SFH_PH_IN && cur_q.instr
        |=> pins.dq_oe == 4'h1)
        else $error("instruction not on lane zero");
    AST_PAUSE_HOLD: assert property (@(posedge clk_sys) disable iff (reset)
        st_q == ST_PAUSE |=> $stable(pins.sck))
        else $error("sck moved during pause");
    AST_READY_AFTER_WAIT: assert property (@(posedge clk_sys) disable iff (reset)
        $rose(link_ready) |-> $past(st_q, 1) == ST_STANDBY)
        else $error("ready without standby");
endmodule

/* File: sfh_pkg.sv */
package sfh_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int SYS_CLK_MHZ          = 200;                  // system clock rate
    localparam int POWERUP_WAIT_US      = 300;                  // powerup_wait_time, plain default
    localparam int POWERUP_WAIT_CYC     = POWERUP_WAIT_US * SYS_CLK_MHZ;
    localparam int HWRESET_PULSE_NS     = 200;                  // reset pulse, plain default
    localparam int HWRESET_PULSE_CYC    = (HWRESET_PULSE_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int HWRESET_RECOVER_NS   = 100;                  // recovery after release, plain default
    localparam int HWRESET_RECOVER_CYC  = (HWRESET_RECOVER_NS * SYS_CLK_MHZ + 999) / 1000;
    // sck half period in clk_sys cycles; four leaves room for the two flop lane delay,
    // so data launched on a fall is settled in dq_s before the next rise samples it
    localparam int SCK_HALF_CYC         = 4;

    // ------------------------------------------------------------
    // widths and reset values
    // ------------------------------------------------------------
    localparam int         CNT_W       = 24;                    // wait counter width
    localparam logic [3:0] LANE_OE_OFF = 4'h0;                  // no lane driven
    localparam logic [7:0] BYTE_ZERO   = 8'h00;                 // idle byte

    // phase kinds and lane widths of a host request
    typedef enum logic [1:0] {SFH_PH_IN, SFH_PH_DUMMY, SFH_PH_OUT, SFH_PH_END} sfh_phase_e;
    typedef enum logic [1:0] {SFH_W_SINGLE, SFH_W_DUAL, SFH_W_QUAD, SFH_W_QPP} sfh_width_e;

    // one phase request from the user side
    typedef struct packed {
        sfh_phase_e phase;    // what the phase does
        sfh_width_e width;    // lanes used
        logic       ddr;      // both sck edges carry data
        logic       instr;    // instruction byte, always single lane
        logic [7:0] data;     // byte to send (inputs), ignored otherwise
    } sfh_req_s;

    // pin drive towards the flash
    typedef struct packed {
        logic       sck;
        logic       cs_n;
        logic       reset_n;
        logic [3:0] dq_o;
        logic [3:0] dq_oe;
    } sfh_pins_s;

    // lanes driven by the host for an input phase
    function automatic logic [3:0] sfh_lane_mask(input sfh_width_e w, input logic instr);
        if (instr) return 4'h1;
        case (w)
            SFH_W_SINGLE: return 4'h1;
            SFH_W_QPP:    return 4'h1;
            SFH_W_DUAL:   return 4'h3;
            default:      return 4'hf;
        endcase
    endfunction

    // bits moved per sck edge of a phase
    function automatic logic [3:0] sfh_bits_per_beat(input sfh_width_e w, input logic instr);
        if (instr) return 4'h1;
        case (w)
            SFH_W_DUAL: return 4'h2;
            SFH_W_QUAD: return 4'h4;
            default:    return 4'h1;
        endcase
    endfunction

endpackage

/* File: sfh_sync2.sv */
// two flop synchroniser for a level crossing into clk
module sfh_sync2 import sfh_pkg::*; #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         reset,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    // ------------------------------------------------------------
    // stages
    // ------------------------------------------------------------
    logic [W-1:0] meta_q;   // first stage, read only by dout

    // first stage feeds nothing but the second
    always_ff @(posedge clk) begin
        if (reset) begin
            meta_q <= '0;
            dout   <= '0;
        end else begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end
endmodule

/* File: tb.sv */
module tb import sfh_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    localparam int PCYC  = 20;     // short powerup wait for simulation
    localparam int LIMIT = 20000;  // run ceiling in clk_sys cycles
    logic clk_sys = 1'b0, reset = 1'b1, clk_link = 1'b0;
    logic hw_reset_req = 1'b0, pause_req = 1'b0, req_valid = 1'b0;
    sfh_req_s req = '0;
    logic req_ready, rsp_valid, link_ready, link_sample_q;
    logic [7:0] rsp_data, out_byte = 8'h00;
    logic [3:0] dq_i;
    sfh_pins_s pins;
    logic [2:0] out_w = 3'h0;      // memory output width, 0 when silent
    logic ddr_m = 1'b0;            // memory samples both edges
    logic [3:0][15:0] lane_log;
    int n_fail = 0, check_count = 0, cyc = 0;

    sfh_host #(.POWERUP_CYC(PCYC)) dut (.clk_sys(clk_sys), .reset(reset),
        .clk_link(clk_link), .hw_reset_req(hw_reset_req), .pause_req(pause_req),
        .req_valid(req_valid), .req(req), .req_ready(req_ready), .rsp_data(rsp_data),
        .rsp_valid(rsp_valid), .link_ready(link_ready), .link_sample_q(link_sample_q),
        .dq_i(dq_i), .pins(pins));
    sfh_flash_model mem (.sck(pins.sck), .cs_n(pins.cs_n), .reset_n(pins.reset_n),
        .dq_o(pins.dq_o), .dq_oe(pins.dq_oe), .out_w(out_w), .out_byte(out_byte),
        .ddr(ddr_m), .dq_i(dq_i), .lane_log(lane_log));

    // ------------------------------------------------------------
    // clocks and run ceiling
    // ------------------------------------------------------------
    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end
    initial begin
        #1.3;
        forever #3 clk_link = ~clk_link;
    end
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            n_fail++;
            give_verdict();
        end
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_rng(input string what, input int lo, input int hi, input int got);
        check_count++;
        if (got < lo || got > hi) begin
            n_fail++;
            $display("wrong value %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    function automatic int nw(input sfh_width_e w);
        return (w == SFH_W_QUAD) ? 4 : (w == SFH_W_DUAL) ? 2 : 1;
    endfunction
    // byte from the last beats seen by the memory, lane 0 least significant
    function automatic logic [7:0] rebuild(input int w);
        logic [7:0] r;
        r = 8'h00;
        for (int b = 0; b < 8 / w; b++)
            for (int l = 0; l < w; l++) r[8 - w * (b + 1) + l] = lane_log[l][8 / w - 1 - b];
        return r;
    endfunction
    // request held until taken; memory mode follows the taken phase
    task automatic send(input sfh_phase_e ph, input sfh_width_e w, input logic d,
                        input logic i, input logic [7:0] b);
        int k;
        k = 0;
        @(negedge clk_sys);
        req_valid = 1'b1;
        req = '{ph, w, d, i, b};
        do begin
            @(posedge clk_sys);
            k++;
        end while (req_ready !== 1'b1 && k < 3000);
        @(negedge clk_sys);
        req_valid = 1'b0;
        ddr_m = d;
        out_w = (ph == SFH_PH_OUT) ? 3'(nw(w)) : 3'h0;
        if (k >= 3000) n_fail++;
    endtask
    task automatic end_frame;
        int k;
        k = 0;
        send(SFH_PH_END, SFH_W_SINGLE, 1'b0, 1'b0, 8'h00);
        while (pins.cs_n !== 1'b1 && k < 100) begin
            tick(1);
            k++;
        end
        tick(2);
        chk("cs_n idle", 1'b1, pins.cs_n);
        chk("dq_oe idle", 4'h0, pins.dq_oe);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_in(input sfh_width_e w, input logic d, input logic [7:0] b);
        send(SFH_PH_IN, SFH_W_SINGLE, 1'b0, 1'b1, 8'ha5);
        send(SFH_PH_IN, w, d, 1'b0, b);
        tick(2);
        chk("dq_oe in", (w == SFH_W_QUAD) ? 4'hf : (w == SFH_W_DUAL) ? 4'h3 : 4'h1,
            pins.dq_oe);
        chk("cs_n in", 1'b0, pins.cs_n);
        end_frame();
        chk("lane data", b, rebuild(nw(w)));
        chk("instr", 8'ha5, lane_log[0][8 / nw(w) + 7 -: 8]);
    endtask
    task automatic t_out(input sfh_width_e w, input logic [7:0] b);
        int k;
        k = 0;
        out_byte = b;
        send(SFH_PH_IN, SFH_W_SINGLE, 1'b0, 1'b1, 8'h6b);
        send(SFH_PH_DUMMY, w, 1'b0, 1'b0, 8'h00);
        tick(2);
        chk("dq_oe dummy", 4'h0, pins.dq_oe);
        send(SFH_PH_OUT, w, 1'b0, 1'b0, 8'h00);
        tick(2);
        chk("dq_oe out", 4'h0, pins.dq_oe);
        while (rsp_valid !== 1'b1 && k < 200) begin
            @(negedge clk_sys);
            k++;
        end
        chk("rsp_valid", 1'b1, rsp_valid);
        chk("rsp_data", b, rsp_data);
        end_frame();
    endtask
    // pause mid-dummy: clock must stand low with select still low
    task automatic t_pause;
        int moves;
        moves = 0;
        send(SFH_PH_IN, SFH_W_SINGLE, 1'b0, 1'b1, 8'h0b);
        send(SFH_PH_DUMMY, SFH_W_SINGLE, 1'b0, 1'b0, 8'h00);
        tick(3);
        pause_req = 1'b1;
        tick(8);
        repeat (12) begin
            tick(1);
            if (pins.sck !== 1'b0) moves++;
        end
        chk("sck moves", 16'h0000, moves[15:0]);
        chk("cs_n paused", 1'b0, pins.cs_n);
        chk("link select", 1'b1, link_sample_q);
        pause_req = 1'b0;
        end_frame();
    endtask
    task automatic t_hwreset;
        int k, low, bad;
        k = 0;
        low = 0;
        bad = 0;
        hw_reset_req = 1'b1;
        while (pins.reset_n !== 1'b0 && k < 50) begin
            tick(1);
            k++;
        end
        hw_reset_req = 1'b0;
        while (pins.reset_n === 1'b0 && low < 500) begin
            if (pins.cs_n !== 1'b1 || pins.dq_oe !== 4'h0) bad++;
            tick(1);
            low++;
        end
        chk_rng("reset pulse", HWRESET_PULSE_CYC, HWRESET_PULSE_CYC + 2, low);
        chk("pins in reset", 16'h0000, bad[15:0]);
        k = 0;
        while (link_ready !== 1'b1 && k < 300) begin
            tick(1);
            k++;
        end
        chk_rng("recovery", HWRESET_RECOVER_CYC, HWRESET_RECOVER_CYC + 8, k);
    endtask

    // ------------------------------------------------------------
    // main sequence and verdict
    // ------------------------------------------------------------
    task automatic give_verdict;
        if (n_fail == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        int k;
        k = 0;
        repeat (5) @(negedge clk_sys);
        chk("cs_n reset", 1'b1, pins.cs_n);
        chk("dq_oe reset", 4'h0, pins.dq_oe);
        chk("req_ready reset", 1'b0, req_ready);
        reset = 1'b0;
        while (link_ready !== 1'b1 && k < 1000) begin
            tick(1);
            k++;
        end
        chk_rng("powerup wait", PCYC, PCYC + 3, k);
        chk("link idle", 1'b0, link_sample_q);
        t_in(SFH_W_SINGLE, 1'b0, 8'h96);
        t_in(SFH_W_DUAL, 1'b0, 8'h6c);
        t_in(SFH_W_QUAD, 1'b0, 8'h3e);
        t_in(SFH_W_QPP, 1'b0, 8'hc5);
        t_in(SFH_W_SINGLE, 1'b1, 8'h59);
        t_in(SFH_W_DUAL, 1'b1, 8'hb2);
        t_in(SFH_W_QUAD, 1'b1, 8'h4d);
        t_out(SFH_W_SINGLE, 8'h5a);
        t_out(SFH_W_DUAL, 8'ha7);
        t_out(SFH_W_QUAD, 8'he1);
        t_pause();
        t_hwreset();
        t_in(SFH_W_SINGLE, 1'b0, 8'h3c);
        give_verdict();
    end
endmodule
